// >>> rtl/timer_consts.svh
// Offsets, field positions, reset values and timing figures of the down timer
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define RELOAD_LO_ADDR 8'ha0
`define RELOAD_HI_ADDR 8'ha1
`define UFLOW_SRC_ADDR 8'ha2
`define CONTROL_ADDR 8'ha3
`define COUNT_LO_ADDR 8'ha4
`define COUNT_HI_ADDR 8'ha5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UFLOW_FLAG_BIT 0
`define CTL_ENABLE_BIT 0
`define CTL_RESET_BIT 1
`define CTL_STOP_BIT 2
`define CTL_STATUS_BIT 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RELOAD_RESET 16'hffff
`define COUNT_RESET 16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLOCK_PERIOD_NS 8
`define TICK_PERIOD_NS 1000000
`define SETTLE_TIME_NS 200000

`endif

// >>> rtl/timer_pkg.sv
// Types shared by the down timer modules
package timer_pkg;
  typedef enum logic [1:0] {
    ST_HALTED,
    ST_RUNNING,
    ST_STOPPING,
    ST_RESETTING
  } timer_state_t;

  typedef logic [15:0] count_t;
endpackage

// >>> rtl/ms_tick_divider.sv
// Divider that turns the core clock into a one-cycle millisecond tick
module ms_tick_divider #(
  parameter int TICK_CYCLES = 125000
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic run_in,
  output logic tick_out
);
  logic [23:0] div_count;

  // Restarts whenever the timer stops, so each run begins with a full period
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_count <= 24'h000000;
    end else if (!run_in || div_count == 24'(TICK_CYCLES - 1)) begin
      div_count <= 24'h000000;
    end else begin
      div_count <= div_count + 24'h000001;
    end
  end

  assign tick_out = run_in && (div_count == 24'(TICK_CYCLES - 1));
endmodule

// >>> rtl/general_purpose_down_timer.sv
// General purpose 16-bit millisecond down timer with byte register port
// How it works
// - Reload value is 16 bits in milliseconds, resets to all ones.
// - Underflow sets bit 0 of the underflow source; writing one clears it.
// - Timer interrupt stays high while the underflow flag is set.
// - In stop mode the flag sets only after the timer has fully halted.
// - Control bit 7 reads one while running, zero when halted.
// - Control bit 2 stops the timer on underflow and clears enable.
// - Control bit 1 stops the timer and reloads the counter.
// - Reset bit clears itself only after the settle time has elapsed.
// - Enable bit starts or stops counting without reloading the count.
// - Count register returns the counter; read it with the timer disabled.
`include "timer_consts.svh"

module general_purpose_down_timer
  import timer_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLOCK_PERIOD_NS,
  parameter int SETTLE_CYCLES = (`SETTLE_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [7:0] rdata_out,
  output logic timer_interrupt_out
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  timer_state_t state;
  timer_state_t next_state;
  count_t timer_reload_value;
  count_t timer_count_value;
  logic underflow_flag;
  logic enable_bit;
  logic stop_on_underflow;
  logic [23:0] settle_count;
  logic ms_tick;
  logic running;
  logic reset_bit;
  logic settle_done;
  logic underflow;
  logic reset_request;
  logic ctl_write;
  logic flag_clear;
  logic [7:0] read_value;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  assign ctl_write = write_in && hit(addr_in, `CONTROL_ADDR);
  // A reset request during a reset in progress is simply absorbed
  assign reset_request = ctl_write && wdata_in[`CTL_RESET_BIT];
  assign flag_clear = write_in && hit(addr_in, `UFLOW_SRC_ADDR) && wdata_in[`UFLOW_FLAG_BIT];
  assign running = (state == ST_RUNNING) || (state == ST_STOPPING);
  assign reset_bit = (state == ST_RESETTING);
  assign settle_done = (settle_count == 24'(SETTLE_CYCLES - 1));
  assign underflow = (state == ST_RUNNING) && ms_tick && (timer_count_value <= 16'h0001);

  // ----------------------------------------
  // Millisecond tick
  // ----------------------------------------
  ms_tick_divider #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .run_in(state == ST_RUNNING),
    .tick_out(ms_tick)
  );

  // ----------------------------------------
  // Control state machine
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_HALTED: begin
        if (reset_request) begin
          next_state = ST_RESETTING;
        end else if (enable_bit) begin
          next_state = ST_RUNNING;
        end
      end
      ST_RUNNING: begin
        if (reset_request) begin
          next_state = ST_RESETTING;
        end else if (underflow && stop_on_underflow) begin
          next_state = ST_STOPPING;
        end else if (!enable_bit) begin
          next_state = ST_HALTED;
        end
      end
      ST_STOPPING: begin
        if (reset_request) begin
          next_state = ST_RESETTING;
        end else if (settle_done) begin
          next_state = ST_HALTED;
        end
      end
      ST_RESETTING: begin
        if (settle_done) begin
          next_state = ST_HALTED;
        end
      end
      default: begin
        next_state = ST_HALTED;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_HALTED;
    end else begin
      state <= next_state;
    end
  end

  // Settle time models the slow propagation of halt and reset through the timer
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      settle_count <= 24'h000000;
    end else if (next_state != state || !(reset_bit || state == ST_STOPPING)) begin
      settle_count <= 24'h000000;
    end else begin
      settle_count <= settle_count + 24'h000001;
    end
  end

  // ----------------------------------------
  // Software controlled fields
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timer_reload_value <= `RELOAD_RESET;
    end else if (write_in && hit(addr_in, `RELOAD_LO_ADDR)) begin
      timer_reload_value[7:0] <= wdata_in;
    end else if (write_in && hit(addr_in, `RELOAD_HI_ADDR)) begin
      timer_reload_value[15:8] <= wdata_in;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      enable_bit <= 1'b0;
      stop_on_underflow <= 1'b0;
    end else begin
      if (underflow && stop_on_underflow) begin
        enable_bit <= 1'b0;
      end else if (ctl_write) begin
        enable_bit <= wdata_in[`CTL_ENABLE_BIT];
      end
      if (ctl_write) begin
        stop_on_underflow <= wdata_in[`CTL_STOP_BIT];
      end
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timer_count_value <= `COUNT_RESET;
    end else if (reset_request || reset_bit) begin
      timer_count_value <= timer_reload_value;
    end else if (underflow) begin
      // Stop mode parks at zero; otherwise start the next period at once
      timer_count_value <= stop_on_underflow ? 16'h0000 : timer_reload_value;
    end else if (state == ST_RUNNING && ms_tick) begin
      timer_count_value <= timer_count_value - 16'h0001;
    end
  end

  // ----------------------------------------
  // Underflow flag
  // ----------------------------------------
  // A new underflow wins over a clear written in the same cycle
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      underflow_flag <= 1'b0;
    end else if (underflow && !stop_on_underflow) begin
      underflow_flag <= 1'b1;
    end else if (state == ST_STOPPING && settle_done && !reset_request) begin
      underflow_flag <= 1'b1;
    end else if (flag_clear) begin
      underflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timer_interrupt_out <= 1'b0;
    end else begin
      timer_interrupt_out <= underflow_flag;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_comb begin
    read_value = 8'h00;
    if (hit(addr_in, `RELOAD_LO_ADDR)) begin
      read_value = timer_reload_value[7:0];
    end else if (hit(addr_in, `RELOAD_HI_ADDR)) begin
      read_value = timer_reload_value[15:8];
    end else if (hit(addr_in, `UFLOW_SRC_ADDR)) begin
      read_value = {7'h00, underflow_flag};
    end else if (hit(addr_in, `CONTROL_ADDR)) begin
      read_value = {running, 4'h0, stop_on_underflow, reset_bit, enable_bit};
    end else if (hit(addr_in, `COUNT_LO_ADDR)) begin
      read_value = timer_count_value[7:0];
    end else if (hit(addr_in, `COUNT_HI_ADDR)) begin
      read_value = timer_count_value[15:8];
    end
  end

  // Bytes of the count are read separately; a running count may tear between them
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= 8'h00;
    end else if (read_in) begin
      rdata_out <= read_value;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);

  sequence reset_starts;
    reset_request && !reset_bit;
  endsequence

  sequence reset_holds;
    reset_bit && !running && timer_count_value == timer_reload_value;
  endsequence

  AST_RELOAD_WRITE: assert property (
    write_in && hit(addr_in, `RELOAD_HI_ADDR) |=> timer_reload_value[15:8] == $past(wdata_in)
  ) else $error("reload high byte not stored");

  AST_FLAG_ON_UFLOW: assert property (
    underflow && !stop_on_underflow |=> underflow_flag ##1 timer_interrupt_out
  ) else $error("underflow did not raise the flag");

  AST_INT_HOLDS: assert property (
    underflow_flag && !flag_clear |=> underflow_flag && timer_interrupt_out
  ) else $error("interrupt dropped while flag set");

  AST_FLAG_AFTER_HALT: assert property (
    $rose(underflow_flag) && $past(stop_on_underflow) |-> !running
  ) else $error("flag set before timer halted");

  AST_STATUS_START: assert property (
    $rose(running) |-> $past(enable_bit) && !reset_bit
  ) else $error("status rose without enable");

  AST_STOP_CLEARS_ENABLE: assert property (
    underflow && stop_on_underflow && !reset_request
    |=> !enable_bit && running
        && underflow_flag == ($past(underflow_flag) && !$past(flag_clear))
  ) else $error("stop mode did not clear enable");

  AST_RESET_LOADS: assert property (
    reset_starts |=> reset_holds [*2]
  ) else $error("reset did not stop and reload");

  AST_RESET_SETTLES: assert property (
    $fell(reset_bit) |-> $past(settle_count) == 24'(SETTLE_CYCLES - 1)
  ) else $error("reset bit cleared early");

  AST_ENABLE_KEEPS_COUNT: assert property (
    ctl_write && !wdata_in[`CTL_RESET_BIT] && !ms_tick && !reset_bit |=> $stable(timer_count_value)
  ) else $error("enable change altered the count");

  AST_DECREMENT: assert property (
    state == ST_RUNNING && ms_tick && timer_count_value > 16'h0001 && !reset_request
    |=> timer_count_value == $past(timer_count_value) - 16'h0001
  ) else $error("count did not decrement on tick");

  AST_RESET_TRACKS: assert property (
    reset_bit |=> timer_count_value == $past(timer_reload_value)
  ) else $error("count not held at reload during reset");

  AST_HALT_FREEZES: assert property (
    state == ST_HALTED && !reset_request |=> $stable(timer_count_value)
  ) else $error("count moved while halted");

  AST_INT_FOLLOWS: assert property (
    !underflow_flag |=> !timer_interrupt_out
  ) else $error("interrupt high without flag");
endmodule

// >>> tb/general_purpose_down_timer_tb.sv
// Self-checking bench for the millisecond down timer register port
module general_purpose_down_timer_tb
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Short counts keep the run brief
  // ----------------------------------------
  localparam int TICK = 10;
  // Settle outlasts a few reads so the in-between state is visible
  localparam int SETTLE = 40;

  logic clock_in;
  logic rstn_in;
  logic [7:0] addr_in;
  logic [7:0] wdata_in;
  logic write_in;
  logic read_in;
  logic [7:0] rdata_out;
  logic timer_interrupt_out;
  int n_errors;
  int total_checks;
  int reload;
  int cnt;

  general_purpose_down_timer #(.TICK_CYCLES(TICK), .SETTLE_CYCLES(SETTLE)) u_dut (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .write_in(write_in),
    .read_in(read_in),
    .rdata_out(rdata_out),
    .timer_interrupt_out(timer_interrupt_out)
  );

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  // ----------------------------------------
  // Bus tasks and compares
  // ----------------------------------------
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    addr_in = a;
    wdata_in = d;
    write_in = 1'b1;
    @(negedge clock_in);
    write_in = 1'b0;
  endtask

  task automatic chk_reg(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock_in);
    addr_in = a;
    read_in = 1'b1;
    @(negedge clock_in);
    read_in = 1'b0;
    @(negedge clock_in);
    total_checks++;
    if (rdata_out !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, rdata_out);
    end
  endtask

  task automatic chk_irq(input logic exp);
    total_checks++;
    if (timer_interrupt_out !== exp) begin
      n_errors++;
      $display("ERROR timer_interrupt expected %b seen %b", exp, timer_interrupt_out);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock_in);
    n_errors++;
    close_out();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rstn_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 8'h00;
    write_in = 1'b0;
    read_in = 1'b0;
    n_errors = 0;
    total_checks = 0;
    void'($urandom(27));
    repeat (6) @(posedge clock_in);
    @(negedge clock_in);
    rstn_in = 1'b1;

    chk_reg("reload_lo", 8'ha0, 8'hff);
    chk_reg("reload_hi", 8'ha1, 8'hff);
    chk_reg("uflow_src", 8'ha2, 8'h00);
    chk_reg("control", 8'ha3, 8'h00);
    chk_reg("count_lo", 8'ha4, 8'h00);
    chk_reg("unmapped", 8'h9c, 8'h00);
    chk_irq(1'b0);
    $display("test reset_values done");

    // Short random reload keeps underflow waits small
    reload = 3 + int'($urandom % 4);
    wr(8'ha0, 8'(reload));
    wr(8'ha1, 8'h00);
    wr(8'ha4, 8'h55);
    wr(8'ha3, 8'hf8);
    chk_reg("reload_lo", 8'ha0, 8'(reload));
    chk_reg("reload_hi", 8'ha1, 8'h00);
    chk_reg("count_ro", 8'ha4, 8'h00);
    chk_reg("control_ro", 8'ha3, 8'h00);
    $display("test reload_access done");

    wr(8'ha3, 8'h02);
    chk_reg("ctl_in_reset", 8'ha3, 8'h02);
    wait_cyc(SETTLE);
    chk_reg("ctl_reset_done", 8'ha3, 8'h00);
    chk_reg("count_loaded", 8'ha4, 8'(reload));
    $display("test reset_bit done");

    // One tick and a half of running, then a halted read
    wr(8'ha3, 8'h01);
    wait_cyc(2);
    chk_reg("ctl_running", 8'ha3, 8'h81);
    wait_cyc(TICK);
    wr(8'ha3, 8'h00);
    cnt = reload - 1;
    chk_reg("ctl_halted", 8'ha3, 8'h00);
    chk_reg("count_one_tick", 8'ha4, 8'(cnt));
    chk_reg("count_hi", 8'ha5, 8'h00);
    $display("test count_down done");

    // Resume without reload and run just past underflow
    wr(8'ha3, 8'h01);
    wait_cyc(cnt * TICK + TICK / 2);
    wr(8'ha3, 8'h00);
    chk_reg("count_reloaded", 8'ha4, 8'(reload));
    chk_reg("uflow_set", 8'ha2, 8'h01);
    chk_irq(1'b1);
    wr(8'ha2, 8'h01);
    wait_cyc(3);
    chk_irq(1'b0);
    chk_reg("uflow_clear", 8'ha2, 8'h00);
    $display("test free_run_underflow done");

    // Stop mode: flag waits for the halt to finish
    wr(8'ha3, 8'h05);
    wait_cyc(reload * TICK + 5);
    chk_reg("uflow_held", 8'ha2, 8'h00);
    chk_reg("ctl_stopping", 8'ha3, 8'h84);
    wait_cyc(SETTLE);
    chk_reg("ctl_stopped", 8'ha3, 8'h04);
    chk_reg("uflow_late", 8'ha2, 8'h01);
    chk_irq(1'b1);
    chk_reg("count_zero", 8'ha4, 8'h00);
    wr(8'ha2, 8'h01);
    wait_cyc(3);
    chk_irq(1'b0);
    $display("test stop_on_underflow done");

    // Reset while running stops and reloads; enable survives the reset
    wr(8'ha3, 8'h01);
    wr(8'ha3, 8'h03);
    chk_reg("ctl_reset_run", 8'ha3, 8'h03);
    wait_cyc(SETTLE);
    chk_reg("ctl_rerun", 8'ha3, 8'h81);
    wr(8'ha3, 8'h00);
    chk_reg("count_after_reset", 8'ha4, 8'(reload));
    chk_reg("uflow_none", 8'ha2, 8'h00);
    $display("test reset_while_running done");

    close_out();
  end
endmodule
